// *** rtl/irq_unit_map.svh ***
`ifndef IRQ_UNIT_MAP_SVH
`define IRQ_UNIT_MAP_SVH
// register indices; byte address is four times the index
`define IDX_SERIAL_PRIO     6'h04
`define IDX_TIMER_PRIO      6'h06
`define IDX_FAST0_SELECT    6'h0B
`define IDX_FAST0_VEC_LOW   6'h0C
`define IDX_FAST0_VEC_HIGH  6'h0D
`define IDX_FAST1_SELECT    6'h0E
`define IDX_FAST1_VEC_LOW   6'h0F
`define IDX_FAST1_VEC_HIGH  6'h10
`define IDX_CONTROL         6'h1D
`define IDX_CAN2_PRIO       6'h1F
// writable bits of each register
`define MASK_SERIAL_PRIO    16'h033F
`define MASK_TIMER_PRIO     16'hFFC0
`define MASK_CAN2_PRIO      16'h003F
`define MASK_FAST_SELECT    16'h007F
`define MASK_VEC_LOW        16'hFFFF
`define MASK_VEC_HIGH       16'h001F
`define MASK_CONTROL        16'h0023
// control register fields
`define CTL_IRQ_ACTIVE      15
`define CTL_MASK_LSB        13
`define CTL_VECTOR_LSB      6
`define CTL_BLOCK           5
`define CTL_FIXED_ONE       4
`define CTL_PIN_B_LEVEL     3
`define CTL_PIN_A_LEVEL     2
`define CTL_PIN_B_EDGE      1
`define CTL_PIN_A_EDGE      0
// priority field encodings
`define PRIO_DISABLED       2'h0
`define PRIO_LEVEL2         2'h3
`define RESET_REG_VALUE     16'h0000
`define EXT_PIN_FIELD       2'h1
`endif

// *** rtl/irq_unit_pkg.sv ***
package irq_unit_pkg;
	// request presented to the core
	typedef struct packed {
		logic        req;
		logic [1:0]  level;
		logic        fast;
		logic [6:0]  vector_number;
		logic [20:0] vector_addr;
	} core_request_t;
endpackage

// *** rtl/interrupt_priority_controller.sv ***
`timescale 1ns/1ps
`include "irq_unit_map.svh"
// How it works
// [R1] field 00 off, 01..11 levels 0..2
// [R2] serial register field positions as documented
// [R3] timer register field positions as documented
// [R4] can2 register: wakeup, error, busoff fields
// [R5] reserved bits read zero, writes ignored
// [R6] control bit 4 always reads one
// [R7] fast0 select holds seven-bit vector number
// [R8] taken fast interrupt supplies programmed address
// [R9] software keeps fast sources at level 2
// [R10] fast source beats every non-fast level-2 request
// [R11] fast 0 wins over fast 1
// [R12] fast0 address: low 16 plus high 5
// [R13] control bit 15 shows request to core
// [R14] bits 14-13 capture new mask on entry
// [R15] bits 12-6 capture last taken vector number
// [R16] block bit stops all requests to core
// [R17] reset vector until second edge after release
// [R18] reset leaves every peripheral source disabled
// [R19] highest level wins, lower vector on ties
// [R20] control shows pin levels, selects edge mode
module interrupt_priority_controller
	import irq_unit_pkg::*;
#(
	parameter int              NUM_PERIPH   = 12,
	parameter logic [20:0]     RESET_VECTOR = 21'h000000,
	parameter logic [20:0]     TABLE_BASE   = 21'h000000,
	parameter logic [14*7-1:0] SRC_VECTORS  = {
		7'h2D, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28, 7'h27,
		7'h26, 7'h25, 7'h24, 7'h23, 7'h22, 7'h21, 7'h20}
)
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NUM_PERIPH-1:0] periph_irq,
	input  wire logic                  ext_pin_a_n,
	input  wire logic                  ext_pin_b_n,
	input  wire logic                  core_ack,
	output core_request_t              core_out
);

	localparam int NSRC = NUM_PERIPH + 2;

	// ==============================================================
	// registers
	logic [15:0] serial_prio;
	logic [15:0] timer_prio;
	logic [15:0] can2_prio;
	logic [6:0]  fast_sel     [2];
	logic [15:0] fast_vec_low [2];
	logic [4:0]  fast_vec_high[2];
	logic        global_irq_block;
	logic        ext_pin_a_edge_select;
	logic        ext_pin_b_edge_select;
	logic [1:0]  nested_priority_mask;
	logic [6:0]  last_vector_number;
	logic        rst_seen;

	// ==============================================================
	// pin synchronisers and external request latches
	logic [1:0] pin_a_sync;
	logic [1:0] pin_b_sync;
	logic       pin_a_prev;
	logic       pin_b_prev;
	logic       pin_a_latch;
	logic       pin_b_latch;
	logic       ext_pin_a_level;
	logic       ext_pin_b_level;

	assign ext_pin_a_level = pin_a_sync[1];
	assign ext_pin_b_level = pin_b_sync[1];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_a_sync <= 2'h3;
			pin_b_sync <= 2'h3;
			pin_a_prev <= 1'b1;
			pin_b_prev <= 1'b1;
		end
		else if (clk_en)
		begin
			pin_a_sync <= {pin_a_sync[0], ext_pin_a_n};
			pin_b_sync <= {pin_b_sync[0], ext_pin_b_n};
			pin_a_prev <= pin_a_sync[1];
			pin_b_prev <= pin_b_sync[1];
		end
	end

	// ==============================================================
	// apb decode
	logic [5:0]  reg_index;
	logic        mapped;
	logic        wr_access;
	logic        rd_setup;
	logic [15:0] wdata;
	logic [15:0] rd_value;

	assign reg_index = paddr[7:2];
	assign wdata     = pwdata[15:0];
	assign wr_access = psel && penable && pwrite && mapped;
	assign rd_setup  = psel && !penable && !pwrite;
	// zero wait states: the read word is fetched in the setup cycle
	assign pready    = psel && penable;
	assign pslverr   = psel && penable && !mapped;

	function automatic logic hits(input logic [5:0] idx);
		return (reg_index == idx) && (paddr[1:0] == 2'h0);
	endfunction

	always_comb
	begin
		mapped = 1'b1;
		unique case (1'b1)
			hits(`IDX_SERIAL_PRIO):    rd_value = serial_prio;
			hits(`IDX_TIMER_PRIO):     rd_value = timer_prio;
			hits(`IDX_CAN2_PRIO):      rd_value = can2_prio;
			hits(`IDX_FAST0_SELECT):   rd_value = {9'h000, fast_sel[0]};          // [R5]
			hits(`IDX_FAST0_VEC_LOW):  rd_value = fast_vec_low[0];
			hits(`IDX_FAST0_VEC_HIGH): rd_value = {11'h000, fast_vec_high[0]};
			hits(`IDX_FAST1_SELECT):   rd_value = {9'h000, fast_sel[1]};
			hits(`IDX_FAST1_VEC_LOW):  rd_value = fast_vec_low[1];
			hits(`IDX_FAST1_VEC_HIGH): rd_value = {11'h000, fast_vec_high[1]};
			hits(`IDX_CONTROL):
			begin
				rd_value = 16'h0000;
				rd_value[`CTL_IRQ_ACTIVE]                 = core_out.req;         // [R13]
				rd_value[`CTL_MASK_LSB+1:`CTL_MASK_LSB]   = nested_priority_mask; // [R14]
				rd_value[`CTL_VECTOR_LSB+6:`CTL_VECTOR_LSB] = last_vector_number; // [R15]
				rd_value[`CTL_BLOCK]       = global_irq_block;
				rd_value[`CTL_FIXED_ONE]   = 1'b1;                                // [R6]
				rd_value[`CTL_PIN_B_LEVEL] = ext_pin_b_level;                     // [R20]
				rd_value[`CTL_PIN_A_LEVEL] = ext_pin_a_level;                     // [R20]
				rd_value[`CTL_PIN_B_EDGE]  = ext_pin_b_edge_select;
				rd_value[`CTL_PIN_A_EDGE]  = ext_pin_a_edge_select;
			end
			default:
			begin
				rd_value = 16'h0000;
				mapped   = 1'b0;
			end
		endcase
	end

	// a read has no side effects, so fetching the word a cycle early is safe
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (clk_en && rd_setup)
			prdata <= {16'h0000, rd_value};
	end

	// ==============================================================
	// register writes; reserved bits are masked off
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_prio <= `RESET_REG_VALUE; // [R18]
			timer_prio  <= `RESET_REG_VALUE;
			can2_prio   <= `RESET_REG_VALUE;
			for (int i = 0; i < 2; i++)
			begin
				fast_sel[i]      <= 7'h00;
				fast_vec_low[i]  <= 16'h0000;
				fast_vec_high[i] <= 5'h00;
			end
			global_irq_block      <= 1'b0;
			ext_pin_a_edge_select <= 1'b0;
			ext_pin_b_edge_select <= 1'b0;
		end
		else if (clk_en && wr_access)
		begin
			if (hits(`IDX_SERIAL_PRIO))
				serial_prio <= wdata & `MASK_SERIAL_PRIO; // [R2] [R5]
			if (hits(`IDX_TIMER_PRIO))
				timer_prio <= wdata & `MASK_TIMER_PRIO;   // [R3]
			if (hits(`IDX_CAN2_PRIO))
				can2_prio <= wdata & `MASK_CAN2_PRIO;     // [R4]
			if (hits(`IDX_FAST0_SELECT))
				fast_sel[0] <= wdata[6:0];                // [R7]
			if (hits(`IDX_FAST0_VEC_LOW))
				fast_vec_low[0] <= wdata;
			if (hits(`IDX_FAST0_VEC_HIGH))
				fast_vec_high[0] <= wdata[4:0];
			if (hits(`IDX_FAST1_SELECT))
				fast_sel[1] <= wdata[6:0];
			if (hits(`IDX_FAST1_VEC_LOW))
				fast_vec_low[1] <= wdata;
			if (hits(`IDX_FAST1_VEC_HIGH))
				fast_vec_high[1] <= wdata[4:0];
			if (hits(`IDX_CONTROL))
			begin
				global_irq_block      <= wdata[`CTL_BLOCK];
				ext_pin_b_edge_select <= wdata[`CTL_PIN_B_EDGE];
				ext_pin_a_edge_select <= wdata[`CTL_PIN_A_EDGE];
			end
		end
	end

	// ==============================================================
	// source table: request, priority field, vector number
	logic [NSRC-1:0] src_req;
	logic [1:0]      src_field [NSRC];
	logic [6:0]      src_vec   [NSRC];

	always_comb
	begin
		src_req = {pin_b_latch, pin_a_latch, periph_irq};
		src_field[0]  = serial_prio[1:0];   // [R2]
		src_field[1]  = serial_prio[3:2];
		src_field[2]  = serial_prio[5:4];
		src_field[3]  = serial_prio[9:8];
		src_field[4]  = timer_prio[7:6];    // [R3]
		src_field[5]  = timer_prio[9:8];
		src_field[6]  = timer_prio[11:10];
		src_field[7]  = timer_prio[13:12];
		src_field[8]  = timer_prio[15:14];
		src_field[9]  = can2_prio[1:0];     // [R4]
		src_field[10] = can2_prio[3:2];
		src_field[11] = can2_prio[5:4];
		src_field[12] = `EXT_PIN_FIELD;
		src_field[13] = `EXT_PIN_FIELD;
		for (int i = 0; i < NSRC; i++)
			src_vec[i] = SRC_VECTORS[i*7 +: 7];
	end

	// ==============================================================
	// arbitration
	// rank: field, then fast 0, then fast 1; lower vector breaks ties
	// a fast source left below level 2 just competes at its own level
	function automatic logic [3:0] rank(input logic [1:0] field, input logic [6:0] vec);
		logic f0;
		logic f1;
		f0 = (field == `PRIO_LEVEL2) && (vec == fast_sel[0]); // [R10]
		f1 = (field == `PRIO_LEVEL2) && (vec == fast_sel[1]);
		return {field, f0, f1 && !f0};                        // [R11]
	endfunction

	logic       win_any;
	logic [3:0] win_rank;
	logic [6:0] win_vec;

	always_comb
	begin
		win_any  = 1'b0;
		win_rank = 4'h0;
		win_vec  = 7'h00;
		for (int i = 0; i < NSRC; i++)
		begin
			// field 00 disables the source entirely
			if (src_req[i] && src_field[i] != `PRIO_DISABLED) // [R1]
			begin
				if (!win_any || rank(src_field[i], src_vec[i]) > win_rank ||
				    (rank(src_field[i], src_vec[i]) == win_rank && src_vec[i] < win_vec)) // [R19]
				begin
					win_any  = 1'b1;
					win_rank = rank(src_field[i], src_vec[i]);
					win_vec  = src_vec[i];
				end
			end
		end
	end

	function automatic logic [20:0] fast_addr(input int slot);
		return {fast_vec_high[slot], fast_vec_low[slot]};
	endfunction

	core_request_t next_core_out;

	always_comb
	begin
		next_core_out.req           = win_any && !global_irq_block; // [R16]
		next_core_out.level         = win_rank[3:2] - 2'h1;          // [R1]
		next_core_out.fast          = win_rank[1] || win_rank[0];
		next_core_out.vector_number = win_vec;
		if (win_rank[1])
			next_core_out.vector_addr = fast_addr(0); // [R8] [R12]
		else if (win_rank[0])
			next_core_out.vector_addr = fast_addr(1); // [R8]
		else
			next_core_out.vector_addr = {TABLE_BASE[20:8], win_vec, 1'b0};
	end

	// ==============================================================
	// core request register; reset vector held through release
	// the extra edge gives the core a clean fetch of the reset vector
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rst_seen <= 1'b0;
		else if (clk_en)
			rst_seen <= 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			core_out             <= '0;
			core_out.vector_addr <= RESET_VECTOR; // [R17]
		end
		else if (clk_en && rst_seen)
			core_out <= next_core_out;            // [R17]
	end

	// ==============================================================
	// capture on handler entry
	logic taken;
	assign taken = core_ack && core_out.req;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			nested_priority_mask <= 2'h0;
			last_vector_number   <= 7'h00;
		end
		else if (clk_en && taken)
		begin
			// taken level n stores mask n+1; the arbiter never reads it
			nested_priority_mask <= core_out.level + 2'h1; // [R14]
			last_vector_number   <= core_out.vector_number; // [R15]
		end
	end

	// edge mode latches a falling edge until taken; a new edge beats the clear
	function automatic logic next_latch(
		input logic edge_mode,
		input logic prev,
		input logic level,
		input logic latch,
		input logic clear
	);
		if (!edge_mode)
			return !level;
		else if (prev && !level)
			return 1'b1;
		else if (clear)
			return 1'b0;
		return latch;
	endfunction

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_a_latch <= 1'b0;
			pin_b_latch <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_a_latch <= next_latch(ext_pin_a_edge_select, pin_a_prev, ext_pin_a_level,
				pin_a_latch, taken && core_out.vector_number == src_vec[NUM_PERIPH]); // [R20]
			pin_b_latch <= next_latch(ext_pin_b_edge_select, pin_b_prev, ext_pin_b_level,
				pin_b_latch, taken && core_out.vector_number == src_vec[NUM_PERIPH+1]); // [R20]
		end
	end

endmodule

// *** tb/irq_unit_asserts.sv ***
`timescale 1ns/1ps
`include "irq_unit_map.svh"
// ============================================================
// port checker: shadows bus writes and handler entries
module irq_unit_asserts
	import irq_unit_pkg::*;
#(
	parameter int          NUM_PERIPH   = 12,
	parameter logic [20:0] RESET_VECTOR = 21'h000000
)
(
	input wire logic          sys_clk,
	input wire logic          rst,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          core_ack,
	input wire core_request_t core_out
);
	localparam logic [7:0] A_CTL = {`IDX_CONTROL, 2'h0};
	localparam logic [7:0] A_SEL = {`IDX_FAST0_SELECT, 2'h0};
	logic        blk;
	logic [8:0]  cap;
	logic [6:0]  sel;
	logic [20:0] adr;
	wire         wr  = psel && penable && pwrite;
	wire         rdc = psel && penable && !pwrite && paddr == A_CTL;
	// shadows move on the committing edge, never on the setup cycle
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			blk <= 1'b0;
			cap <= 9'h000;
			sel <= 7'h00;
			adr <= 21'h000000;
		end
		else
		begin
			if (wr && paddr == A_CTL)
				blk <= pwdata[5];
			if (core_ack && core_out.req)
				cap <= {core_out.level + 2'h1, core_out.vector_number};
			if (wr && paddr == A_SEL)
				sel <= pwdata[6:0];
			if (wr && paddr == A_SEL + 8'h04)
				adr[15:0] <= pwdata[15:0];
			if (wr && paddr == A_SEL + 8'h08)
				adr[20:16] <= pwdata[4:0];
		end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ============================================================
	// properties
	property p_level; core_out.req |-> core_out.level <= 2'h2; endproperty
	a_level: assert property (p_level) else $error("level above two");
	property p_reserved; psel && penable && !pwrite && paddr == A_SEL
		|-> prdata[15:7] == 9'h000; endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");
	property p_fixed_one; rdc |-> prdata[4] && prdata[31:16] == 16'h0000; endproperty
	a_fixed_one: assert property (p_fixed_one) else $error("fixed bit wrong");
	property p_fast_addr; core_out.req && core_out.fast && core_out.vector_number == $past(sel)
		|-> core_out.vector_addr == $past(adr); endproperty
	a_fast_addr: assert property (p_fast_addr) else $error("fast address wrong");
	property p_active; rdc |-> prdata[15] == $past(core_out.req); endproperty
	a_active: assert property (p_active) else $error("active bit wrong");
	property p_mask; rdc |-> prdata[14:13] == $past(cap[8:7]); endproperty
	a_mask: assert property (p_mask) else $error("mask capture wrong");
	property p_vector; rdc |-> prdata[12:6] == $past(cap[6:0]); endproperty
	a_vector: assert property (p_vector) else $error("vector capture wrong");
	property p_block; blk |=> !core_out.req; endproperty
	a_block: assert property (p_block) else $error("request while blocked");
	property p_reset_vec; $fell(rst) |-> core_out.vector_addr == RESET_VECTOR
		##1 core_out.vector_addr == RESET_VECTOR; endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector dropped");
endmodule

bind interrupt_priority_controller irq_unit_asserts #(
	.NUM_PERIPH(NUM_PERIPH), .RESET_VECTOR(RESET_VECTOR)) chk (
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .core_ack(core_ack), .core_out(core_out)
);

// *** tb/core_model.sv ***
`timescale 1ns/1ps
// ============================================================
// core side: enters a handler promptly or after three cycles
module core_model
	import irq_unit_pkg::*;
(
	input wire logic          sys_clk,
	input wire logic          rst,
	input wire logic          slow,
	input wire core_request_t core_out,
	output logic              core_ack
);
	logic [1:0] wait_cnt;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			wait_cnt <= 2'h0;
			core_ack <= 1'b0;
		end
		else
		begin
			core_ack <= 1'b0;
			// never acks twice in a row, so each entry is a one-cycle pulse
			if (core_out.req && !core_ack)
			begin
				if (!slow || wait_cnt == 2'h3)
				begin
					core_ack <= 1'b1;
					wait_cnt <= 2'h0;
				end
				else
					wait_cnt <= wait_cnt + 2'h1;
			end
		end
endmodule

// *** tb/interrupt_priority_controller_test.sv ***
`timescale 1ns/1ps
module interrupt_priority_controller_test
	import irq_unit_pkg::*;
;
	localparam logic [20:0] RV = 21'h1ABCD;
	localparam logic [20:0] TB = 21'h0A5500;
	logic          sys_clk, rst, psel, penable, pwrite, pready, pslverr, core_ack, slow, err;
	logic          ext_pin_a_n, ext_pin_b_n;
	logic [7:0]    paddr;
	logic [11:0]   periph_irq;
	logic [31:0]   pwdata, prdata, rd;
	core_request_t core_out, e;
	int            err_count, checks, cycles;
	logic [15:0]   tv [9];
	// byte address and writable bits, in the order the arbiter reads them
	logic [7:0]    ta [9] = '{8'h10, 8'h18, 8'h7C, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40};
	logic [15:0]   tm [9] = '{16'h033F, 16'hFFC0, 16'h003F, 16'h007F, 16'hFFFF,
		16'h001F, 16'h007F, 16'hFFFF, 16'h001F};

	interrupt_priority_controller #(.RESET_VECTOR(RV), .TABLE_BASE(TB)) uut (
		.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_irq(periph_irq), .ext_pin_a_n(ext_pin_a_n),
		.ext_pin_b_n(ext_pin_b_n), .core_ack(core_ack), .core_out(core_out));
	core_model partner (.sys_clk(sys_clk), .rst(rst), .slow(slow), .core_out(core_out),
		.core_ack(core_ack));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end
	// ============================================================
	// tasks
	task give_verdict;
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [1:0] field(int i);
		case (i)
			0, 1, 2: return tv[0][2*i +: 2];
			3: return tv[0][9:8];
			12: return {1'b0, ~ext_pin_a_n};
			13: return {1'b0, ~ext_pin_b_n};
			default: return i < 9 ? tv[1][2*i - 2 +: 2] : tv[2][2*i - 18 +: 2];
		endcase
	endfunction
	function automatic core_request_t expect_out();
		core_request_t r;
		int best, rank;
		logic [6:0] v;
		r = '0;
		best = 0;
		for (int i = 0; i < 14; i++)
		begin
			v = 7'h20 + 7'(i);
			rank = field(i);
			// fast slots lift only a source already at the top level
			if (rank == 3)
				rank = v == tv[3][6:0] ? 11 : v == tv[6][6:0] ? 7 : 3;
			if ((i > 11 || periph_irq[i]) && rank > best)
			begin
				best = rank;
				r = {1'b1, field(i) - 2'h1, rank > 3, v, TB[20:8], v, 1'b0};
				if (rank == 11)
					r.vector_addr = {tv[5][4:0], tv[4]};
				if (rank == 7)
					r.vector_addr = {tv[8][4:0], tv[7]};
			end
		end
		return r;
	endfunction
	task read_all;
		for (int k = 0; k < 9; k++)
		begin
			apb(1'b0, ta[k], 32'h0);
			check(rd, {16'h0000, tv[k]});
		end
	endtask
	task run_case;
		logic [31:0] m;
		for (int k = 0; k < 9; k++)
			apb(1'b1, ta[k], {16'hFFFF, tv[k] | ~tm[k]});
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		e = expect_out();
		check(e.req ? core_out : {core_out.req, 31'h0}, e);
		apb(1'b0, 8'h74, 32'h0);
		m = e.req ? 32'hFFFF : 32'h803F;
		check(rd & m, {16'h0, e.req, e.level + 2'h1, e.vector_number, 2'h1, ext_pin_b_n,
			ext_pin_a_n, 2'h0} & m);
		read_all();
	endtask
	// ============================================================
	// sequence
	initial
	begin
		{rst, ext_pin_a_n, ext_pin_b_n} = 3'h7;
		{psel, penable, pwrite, slow, paddr, pwdata, periph_irq} = '0;
		{err_count, checks, cycles} = '0;
		tv = '{default: 16'h0000};
		void'($urandom(32'h26DCD1D2));
		@(negedge sys_clk);
		check(core_out, {11'h0, RV});
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(core_out, {11'h0, RV});
		read_all();
		apb(1'b0, 8'h74, 32'h0);
		check(rd, 32'h001C);
		apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		apb(1'b0, 8'hFC, 32'h0);
		check({rd[30:0], err}, 32'h1);
		for (int k = 0; k < 9; k++)
			tv[k] = 16'($urandom) & tm[k];
		tv[0] = 16'h033F;
		tv[1] = 16'hFFC0;
		tv[2] = 16'h003F;
		tv[3] = 16'h0025;
		tv[6] = 16'h0021;
		periph_irq <= 12'hFFF;
		run_case();
		tv[3] = 16'h0000;
		run_case();
		apb(1'b1, 8'h74, 32'h23);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check({31'h0, core_out.req}, 32'h0);
		apb(1'b0, 8'h74, 32'h0);
		check(rd & 32'h003F, 32'h003F);
		apb(1'b1, 8'h74, 32'h0);
		for (int n = 0; n < 40; n++)
		begin
			for (int k = 0; k < 9; k++)
				tv[k] = 16'($urandom) & tm[k];
			tv[3] = 16'h0020 + 16'($urandom % 16);
			tv[6] = 16'h0020 + 16'($urandom % 16);
			periph_irq <= 12'($urandom);
			{slow, ext_pin_b_n, ext_pin_a_n} <= 3'($urandom);
			run_case();
		end
		periph_irq <= 12'h000;
		{ext_pin_b_n, ext_pin_a_n} <= 2'h3;
		apb(1'b1, 8'h74, 32'h1);
		ext_pin_a_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		check({31'h0, core_out.req}, 32'h0);
		apb(1'b0, 8'h74, 32'h0);
		check(rd, 32'h2B19);
		ext_pin_a_n <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b1;
		@(negedge sys_clk);
		check(core_out, {11'h0, RV});
		@(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(core_out, {11'h0, RV});
		tv = '{default: 16'h0000};
		read_all();
		give_verdict();
	end
endmodule
